// *** hw/sad_pkg.sv ***
/*
 * Shared constants for the converter control block and its reader:
 * bus widths, timing figures and the cycle counts derived from them.
 * Assumes a single 250 MHz system clock on both ends.
 */
package sad_pkg;

   localparam int CLK_MHZ        = 250;
   localparam int RESULT_W       = 16;
   localparam int BYTE_W         = 8;
   localparam int CNT_W          = 8;

   // Conversion time, longest figure, rounded down
   localparam int CONV_TIME_NS   = 700;
   localparam int CONV_CYCLES    = (CONV_TIME_NS * CLK_MHZ) / 1000;

   // Trigger low time, least figure, rounded up
   localparam int TRIG_LOW_NS    = 20;
   localparam int TRIG_CYCLES    = (TRIG_LOW_NS * CLK_MHZ + 999) / 1000;

   // Read quiet zone around the trigger falling edge, least figures
   localparam int QUIET_PRE_NS   = 50;
   localparam int QUIET_PRE_CYC  = (QUIET_PRE_NS * CLK_MHZ + 999) / 1000;
   localparam int QUIET_POST_NS  = 40;
   localparam int QUIET_POST_CYC = (QUIET_POST_NS * CLK_MHZ + 999) / 1000;

   // Cycles from read strobe low until the reader samples the bus
   localparam int READ_LAT_CYC   = 3;

   // Conversions after power-on that only load trim data
   localparam int TRIM_CONVS     = 3;

   localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;
   localparam logic [BYTE_W-1:0]   FILL_BYTE    = 8'hFF;

endpackage : sad_pkg

// *** hw/sad_link_if.sv ***
/*
 * Pin-level link between the converter and its reader.
 * Assumes both ends share clk_i; the result bus is modelled as
 * value plus output enable, the bench resolves the wire.
 */
`timescale 1ns/10ps

interface sad_link_if;

   logic                            conversion_trigger_n;
   logic                            select_n;
   logic                            read_n;
   logic                            byte_sel;
   logic                            busy;
   logic [sad_pkg::RESULT_W-1:0]    result_bus_lines;
   logic                            result_bus_oe;

   modport device (
      input  conversion_trigger_n,
      input  select_n,
      input  read_n,
      input  byte_sel,
      output busy,
      output result_bus_lines,
      output result_bus_oe
   );

   modport host (
      output conversion_trigger_n,
      output select_n,
      output read_n,
      output byte_sel,
      input  busy,
      input  result_bus_lines,
      input  result_bus_oe
   );

endinterface : sad_link_if

// *** hw/sad_fifo.sv ***
/*
 * Small synchronous FIFO in flip-flops with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps

module sad_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic [WIDTH-1:0]      out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction : bump

   assign in_ready_o  = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always_comb
   begin
      next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
      next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
      next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // Storage needs no reset; empty flag hides stale words
   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data_i;
      end
   end

endmodule : sad_fifo

// *** hw/sad_device.sv ***
/*
 * Converter end: conversion sequencing, internal reset, result latch
 * and the parallel result bus with byte folding.
 * Assumes link inputs are synchronous to clk_i and the sample code
 * presented by the user side stands for the analog input.
 */
// Functional notes
// - Conversion timed internally, no host clock
// - Host holds trigger low 20 ns, select low
// - Trigger falling edge moves sample to hold
// - Busy high after trigger fall until done
// - Sampling restarts on busy fall or select fall
// - Select must be low at trigger fall
// - Bus driven only when select and read low
// - No reads 50 ns before to 40 ns after trigger
// - Result is unsigned straight binary code
// - Byte select low gives full word
// - Byte select high: low byte up, ones below
// - Byte host reads upper byte twice
// - Multiword reads with toggling or held strobe
// - First three conversions after power-on invalid
// - Trigger fall during conversion causes reset
// - Select fall during conversion causes reset
// - Internal reset clears result, drops busy
// - Sampling begins right after internal reset
// - Conversion lasts 700 ns internally timed
// - Read strobe enables latest result onto bus
`timescale 1ns/10ps

module sad_device #(
   parameter int CONV_CYCLES = sad_pkg::CONV_CYCLES,
   parameter int TRIM_CONVS  = sad_pkg::TRIM_CONVS
) (
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   sad_link_if.device                        link,
   input  wire logic [sad_pkg::RESULT_W-1:0] sample_code_i,
   output logic                              sampling_o,
   output logic                              trim_done_o,
   output logic                              internal_reset_o
);

   typedef enum logic [1:0] {
      DEV_IDLE,
      DEV_SAMPLE,
      DEV_CONVERT
   } sad_dev_state_t;

   sad_dev_state_t                 state;
   sad_dev_state_t                 next_state;
   logic                           trig_d;
   logic                           sel_d;
   logic [sad_pkg::CNT_W-1:0]      cnt;
   logic [sad_pkg::CNT_W-1:0]      next_cnt;
   logic [sad_pkg::RESULT_W-1:0]   held;
   logic [sad_pkg::RESULT_W-1:0]   next_held;
   logic [sad_pkg::RESULT_W-1:0]   result;
   logic [sad_pkg::RESULT_W-1:0]   next_result;
   logic [1:0]                     conv_count;
   logic [1:0]                     next_conv_count;
   logic                           ireset;
   logic                           next_ireset;
   logic [sad_pkg::RESULT_W-1:0]   bus_word;
   logic [sad_pkg::RESULT_W-1:0]   next_bus_word;
   logic                           bus_oe;
   logic                           next_bus_oe;
   logic                           trig_fall;
   logic                           sel_fall;
   logic                           conv_end;

   // Fold the low result byte onto the upper lanes for narrow hosts
   function automatic logic [sad_pkg::RESULT_W-1:0] bus_view(
      input logic [sad_pkg::RESULT_W-1:0] word,
      input logic                         upper_only
   );
      if (upper_only)
      begin
         bus_view = {word[sad_pkg::BYTE_W-1:0], sad_pkg::FILL_BYTE};
      end
      else
      begin
         bus_view = word;
      end
   endfunction : bus_view

   // Edges are taken against the previous sampled level
   assign trig_fall = trig_d & ~link.conversion_trigger_n;
   assign sel_fall  = sel_d & ~link.select_n;
   assign conv_end  = (cnt == sad_pkg::CNT_W'(CONV_CYCLES - 1));

   always_comb
   begin
      next_state      = state;
      next_cnt        = cnt;
      next_held       = held;
      next_result     = result;
      next_conv_count = conv_count;
      next_ireset     = 1'b0;
      unique case (state)
         DEV_CONVERT:
         begin
            if ((trig_fall & ~link.select_n) | sel_fall)
            begin
               // Self-clearing reset: one cycle, then straight to sampling
               next_ireset = 1'b1;
               next_result = sad_pkg::RESULT_RESET;
               next_state  = DEV_SAMPLE;
               next_cnt    = '0;
            end
            else if (conv_end)
            begin
               next_result = held;
               next_cnt    = '0;
               if (conv_count != 2'(TRIM_CONVS))
               begin
                  next_conv_count = conv_count + 2'd1;
               end
               next_state = link.select_n ? DEV_IDLE : DEV_SAMPLE;
            end
            else
            begin
               next_cnt = cnt + sad_pkg::CNT_W'(1);
            end
         end
         DEV_SAMPLE,
         DEV_IDLE:
         begin
            if (trig_fall & ~link.select_n)
            begin
               // Hold the input at the trigger edge
               next_held  = sample_code_i;
               next_cnt   = '0;
               next_state = DEV_CONVERT;
            end
            else if ((state == DEV_IDLE) & sel_fall)
            begin
               next_state = DEV_SAMPLE;
            end
         end
      endcase
   end

   always_comb
   begin
      next_bus_oe   = ~link.select_n & ~link.read_n;
      next_bus_word = bus_view(result, link.byte_sel);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state      <= DEV_SAMPLE;
         cnt        <= '0;
         held       <= sad_pkg::RESULT_RESET;
         result     <= sad_pkg::RESULT_RESET;
         conv_count <= '0;
         ireset     <= 1'b0;
         trig_d     <= 1'b1;
         sel_d      <= 1'b1;
      end
      else
      begin
         state      <= next_state;
         cnt        <= next_cnt;
         held       <= next_held;
         result     <= next_result;
         conv_count <= next_conv_count;
         ireset     <= next_ireset;
         trig_d     <= link.conversion_trigger_n;
         sel_d      <= link.select_n;
      end
   end

   // Bus drivers register the view so word and enable move together
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bus_word <= sad_pkg::RESULT_RESET;
         bus_oe   <= 1'b0;
      end
      else
      begin
         bus_word <= next_bus_word;
         bus_oe   <= next_bus_oe;
      end
   end

   assign link.busy             = (state == DEV_CONVERT);
   assign link.result_bus_lines = bus_word;
   assign link.result_bus_oe    = bus_oe;
   assign sampling_o            = (state == DEV_SAMPLE);
   assign trim_done_o           = (conv_count == 2'(TRIM_CONVS));
   assign internal_reset_o      = ireset;

endmodule : sad_device

// *** hw/sad_host.sv ***
/*
 * Reader end: triggers conversions, waits out busy, reads the result
 * over the full or the folded byte bus and queues it in a FIFO.
 * Assumes the converter shares clk_i and registers its bus drivers.
 */
`timescale 1ns/10ps

module sad_host #(
   parameter int FIFO_DEPTH = 4,
   parameter int DROP_CONVS = sad_pkg::TRIM_CONVS
) (
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   sad_link_if.host                          link,
   input  wire logic                         start_i,
   input  wire logic                         byte_mode_i,
   output logic [sad_pkg::RESULT_W-1:0]      result_o,
   output logic                              result_valid_o,
   input  wire logic                         result_ready_i,
   output logic                              idle_o
);

   typedef enum logic [2:0] {
      H_IDLE, H_TRIG, H_WAIT, H_READ_HI, H_READ_LO, H_PUSH, H_GAP
   } sad_host_state_t;

   sad_host_state_t               state;
   sad_host_state_t               next_state;
   logic [sad_pkg::CNT_W-1:0]     cnt;
   logic [sad_pkg::CNT_W-1:0]     next_cnt;
   logic [sad_pkg::RESULT_W-1:0]  word;
   logic [sad_pkg::RESULT_W-1:0]  next_word;
   logic [1:0]                    drop;
   logic [1:0]                    next_drop;
   logic                          narrow;
   logic                          next_narrow;
   logic                          sel_n;
   logic                          next_sel_n;
   logic                          trig_n;
   logic                          next_trig_n;
   logic                          rd_n;
   logic                          next_rd_n;
   logic                          bsel;
   logic                          next_bsel;
   logic                          push_valid;
   logic                          push_ready;
   logic                          read_due;

   assign read_due   = (cnt == sad_pkg::CNT_W'(sad_pkg::READ_LAT_CYC - 1));
   assign push_valid = (state == H_PUSH) & (drop == 2'(DROP_CONVS));

   always_comb
   begin
      next_state  = state;
      next_cnt    = cnt + sad_pkg::CNT_W'(1);
      next_word   = word;
      next_drop   = drop;
      next_narrow = narrow;
      next_sel_n  = sel_n;
      next_trig_n = 1'b1;
      next_rd_n   = 1'b1;
      next_bsel   = 1'b0;
      unique case (state)
         H_IDLE:
         begin
            next_cnt = '0;
            if (start_i)
            begin
               next_narrow = byte_mode_i;
               next_sel_n  = 1'b0;
               next_trig_n = 1'b0;
               next_state  = H_TRIG;
            end
         end
         H_TRIG:
         begin
            next_trig_n = 1'b0;
            if (cnt == sad_pkg::CNT_W'(sad_pkg::TRIG_CYCLES - 1))
            begin
               next_trig_n = 1'b1;
               next_cnt    = '0;
               next_state  = H_WAIT;
            end
         end
         H_WAIT:
         begin
            // Busy rises before this state is reached, so low means done
            if (~link.busy & (cnt >= sad_pkg::CNT_W'(sad_pkg::QUIET_POST_CYC)))
            begin
               next_rd_n  = 1'b0;
               next_cnt   = '0;
               next_state = H_READ_HI;
            end
         end
         H_READ_HI:
         begin
            next_rd_n = 1'b0;
            if (read_due)
            begin
               next_cnt = '0;
               if (narrow)
               begin
                  next_word[15:8] = link.result_bus_lines[15:8];
                  next_bsel       = 1'b1;
                  next_state      = H_READ_LO;
               end
               else
               begin
                  next_word  = link.result_bus_lines;
                  next_rd_n  = 1'b1;
                  next_state = H_PUSH;
               end
            end
         end
         H_READ_LO:
         begin
            next_rd_n = 1'b0;
            next_bsel = 1'b1;
            if (read_due)
            begin
               next_word[7:0] = link.result_bus_lines[15:8];
               next_rd_n      = 1'b1;
               next_bsel      = 1'b0;
               next_state     = H_PUSH;
            end
         end
         H_PUSH:
         begin
            next_cnt = '0;
            if (drop != 2'(DROP_CONVS))
            begin
               next_drop  = drop + 2'd1;
               next_state = H_GAP;
            end
            else if (push_ready)
            begin
               next_state = H_GAP;
            end
         end
         H_GAP:
         begin
            // Keeps reads clear of the next trigger edge
            if (cnt == sad_pkg::CNT_W'(sad_pkg::QUIET_PRE_CYC - 1))
            begin
               next_sel_n = 1'b1;
               next_state = H_IDLE;
            end
         end
         default:
         begin
            next_state = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state  <= H_IDLE;
         cnt    <= '0;
         word   <= sad_pkg::RESULT_RESET;
         drop   <= '0;
         narrow <= 1'b0;
         sel_n  <= 1'b1;
         trig_n <= 1'b1;
         rd_n   <= 1'b1;
         bsel   <= 1'b0;
      end
      else
      begin
         state  <= next_state;
         cnt    <= next_cnt;
         word   <= next_word;
         drop   <= next_drop;
         narrow <= next_narrow;
         sel_n  <= next_sel_n;
         trig_n <= next_trig_n;
         rd_n   <= next_rd_n;
         bsel   <= next_bsel;
      end
   end

   sad_fifo #(
      .WIDTH (sad_pkg::RESULT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_data_i   (word),
      .in_valid_i  (push_valid),
      .in_ready_o  (push_ready),
      .out_data_o  (result_o),
      .out_valid_o (result_valid_o),
      .out_ready_i (result_ready_i)
   );

   assign link.conversion_trigger_n = trig_n;
   assign link.select_n             = sel_n;
   assign link.read_n               = rd_n;
   assign link.byte_sel             = bsel;
   assign idle_o                    = (state == H_IDLE);

endmodule : sad_host

// *** test/sad_link_checker.sv ***
/*
 * Concurrent checks on the link between the host end and the converter end.
 * Assumes one clock, a synchronous active-high reset and a host that obeys
 * the link rules, so no internal reset occurs on this link.
 */
`timescale 1ns/10ps

module sad_link_checker #(
   parameter int CONV_CYCLES = sad_pkg::CONV_CYCLES
) (
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   input  wire logic                         conversion_trigger_n,
   input  wire logic                         select_n,
   input  wire logic                         read_n,
   input  wire logic                         byte_sel,
   input  wire logic                         busy,
   input  wire logic [sad_pkg::RESULT_W-1:0] result_bus_lines,
   input  wire logic                         result_bus_oe
);

   int busy_len;
   int since_read;

   // Saturating, so a long idle stretch cannot wrap back into the quiet zone
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         busy_len   <= 0;
         since_read <= 1000;
      end
      else
      begin
         busy_len   <= busy ? busy_len + 1 : 0;
         since_read <= !read_n ? 0 : (since_read < 1000 ? since_read + 1 : 1000);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_busy_on_trigger: assert property (!conversion_trigger_n && $past(conversion_trigger_n)
      && !select_n && !busy |=> busy)
      else $error("busy did not rise after trigger fall");
   a_busy_length: assert property ($fell(busy) |-> busy_len == CONV_CYCLES)
      else $error("busy pulse length wrong");
   a_select_at_trigger: assert property ($fell(conversion_trigger_n) |-> !select_n)
      else $error("select high at trigger fall");
   a_trigger_width: assert property ($fell(conversion_trigger_n) |-> !conversion_trigger_n [*5])
      else $error("trigger low time too short");
   a_quiet_after: assert property ($fell(conversion_trigger_n) |-> read_n [*5] ##1 read_n [*5])
      else $error("read inside quiet zone after trigger");
   a_quiet_before: assert property ($fell(conversion_trigger_n) |-> since_read >= sad_pkg::QUIET_PRE_CYC)
      else $error("read inside quiet zone before trigger");
   a_bus_enable: assert property (result_bus_oe == $past(!select_n && !read_n))
      else $error("bus enable does not follow select and read");
   a_fold_fill: assert property (result_bus_oe && $past(byte_sel) |-> result_bus_lines[7:0] == sad_pkg::FILL_BYTE)
      else $error("lower byte not all ones in byte view");
   a_fold_swap: assert property (result_bus_oe && $past(result_bus_oe) && $past(byte_sel) && !$past(byte_sel, 2)
      && !busy |-> result_bus_lines[15:8] == $past(result_bus_lines[7:0]))
      else $error("low result byte not moved to upper lanes");
   a_auto_read: assert property ($rose(byte_sel) |-> !read_n && !select_n)
      else $error("byte select changed outside a held read");

   c_conv_done: cover property ($fell(busy));
   c_byte_read: cover property ($rose(byte_sel));
   c_bus_drive: cover property ($rose(result_bus_oe));

endmodule : sad_link_checker

// *** test/tb_sar_adc_parallel_readout.sv ***
/*
 * Self-checking bench: host and converter joined by one link, plus a second
 * converter whose link is driven by the bench to provoke internal resets.
 * Assumes the design files and the checker are compiled first.
 */
`timescale 1ns/10ps

module tb_sar_adc_parallel_readout;

   localparam int CONV = 8;

   logic                         clk_i          = 1'b0;
   logic                         rst_i          = 1'b1;
   logic                         start_i        = 1'b0;
   logic                         byte_mode_i    = 1'b0;
   logic                         result_ready_i = 1'b0;
   logic [sad_pkg::RESULT_W-1:0] sample_code_i  = 16'h0000;
   logic [sad_pkg::RESULT_W-1:0] code_f         = 16'h0000;
   logic [sad_pkg::RESULT_W-1:0] result_o;
   logic                         result_valid_o;
   logic                         idle_o;
   logic                         trim_done_o;
   logic                         f_sampling;
   logic                         f_irst;
   logic                         f_trig         = 1'b1;
   logic                         f_sel          = 1'b1;
   logic                         f_rd           = 1'b1;
   wire  [sad_pkg::RESULT_W-1:0] bus_wire;
   int                           n_mismatch     = 0;
   int                           check_count    = 0;

   sad_link_if link ();
   sad_link_if link_f ();

   assign link_f.conversion_trigger_n = f_trig;
   assign link_f.select_n             = f_sel;
   assign link_f.read_n               = f_rd;
   assign link_f.byte_sel             = 1'b0;
   assign bus_wire = link.result_bus_oe ? link.result_bus_lines : 16'hZZZZ;

   always #2 clk_i = ~clk_i;

   sad_device #(.CONV_CYCLES(CONV)) i_sad_device (.clk_i(clk_i), .rst_i(rst_i), .link(link),
      .sample_code_i(sample_code_i), .sampling_o(), .trim_done_o(trim_done_o),
      .internal_reset_o());
   sad_host #(.FIFO_DEPTH(4)) i_sad_host (.clk_i(clk_i), .rst_i(rst_i), .link(link),
      .start_i(start_i), .byte_mode_i(byte_mode_i), .result_o(result_o),
      .result_valid_o(result_valid_o), .result_ready_i(result_ready_i), .idle_o(idle_o));
   sad_device #(.CONV_CYCLES(CONV)) i_sad_device_2 (.clk_i(clk_i), .rst_i(rst_i), .link(link_f),
      .sample_code_i(code_f), .sampling_o(f_sampling), .trim_done_o(),
      .internal_reset_o(f_irst));
   sad_link_checker #(.CONV_CYCLES(CONV)) i_sad_link_checker (.clk_i(clk_i), .rst_i(rst_i),
      .conversion_trigger_n(link.conversion_trigger_n), .select_n(link.select_n),
      .read_n(link.read_n), .byte_sel(link.byte_sel), .busy(link.busy),
      .result_bus_lines(link.result_bus_lines), .result_bus_oe(link.result_bus_oe));

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      if (got !== exp)
         n_mismatch++;
   endtask : chk

   // Done stays low when the host stalls, e.g. on a full FIFO
   task automatic run(input logic [15:0] code, input logic mode, output logic done);
      int n;
      @(posedge clk_i);
      sample_code_i <= code;
      byte_mode_i   <= mode;
      start_i       <= 1'b1;
      @(posedge clk_i);
      start_i <= 1'b0;
      tick(1);
      for (n = 0; n < 150 && idle_o !== 1'b1; n++)
         tick(1);
      done = idle_o;
   endtask : run

   task automatic pop(input logic [15:0] exp);
      int n;
      for (n = 0; n < 60 && result_valid_o !== 1'b1; n++)
         tick(1);
      chk(result_o, exp);
      @(posedge clk_i);
      result_ready_i <= 1'b1;
      @(posedge clk_i);
      result_ready_i <= 1'b0;
      // Step off the edge so the next look sees the popped FIFO
      #1;
   endtask : pop

   task automatic f_read(input logic [15:0] exp);
      @(posedge clk_i);
      f_rd <= 1'b0;
      tick(2);
      chk(link_f.result_bus_oe ? link_f.result_bus_lines : 16'hZZZZ, exp);
      @(posedge clk_i);
      f_rd <= 1'b1;
   endtask : f_read

   task automatic wait_busy_low;
      int n;
      for (n = 0; n < 40 && link_f.busy !== 1'b0; n++)
         tick(1);
   endtask : wait_busy_low

   task automatic s_trim_and_codes;
      logic [15:0] codes [5] = '{16'h0000, 16'h8000, 16'h7FFF, 16'hFFFF, 16'h1234};
      logic        d;
      for (int i = 0; i < 3; i++)
      begin
         chk(trim_done_o, 1'b0);
         run(16'h1111, 1'b0, d);
         chk(result_valid_o, 1'b0);
      end
      chk(trim_done_o, 1'b1);
      foreach (codes[i])
      begin
         run(codes[i], 1'b0, d);
         chk(bus_wire, 16'hZZZZ);
         pop(codes[i]);
      end
      run(16'hA5C3, 1'b1, d);
      pop(16'hA5C3);
      $display("test trim and codes done");
   endtask : s_trim_and_codes

   // Far side stalls until the FIFO refuses, then drains it to empty
   task automatic s_fifo;
      logic d;
      for (int i = 0; i < 5; i++)
      begin
         run(16'h0100 | 16'(i), 1'b0, d);
         chk(d, (i < 4) ? 1'b1 : 1'b0);
      end
      for (int i = 0; i < 5; i++)
         pop(16'h0100 | 16'(i));
      tick(40);
      chk(result_valid_o, 1'b0);
      $display("test fifo done");
   endtask : s_fifo

   task automatic s_abort;
      @(posedge clk_i);
      code_f <= 16'hBEEF;
      f_sel  <= 1'b0;
      @(posedge clk_i);
      f_trig <= 1'b0;
      repeat (5) @(posedge clk_i);
      f_trig <= 1'b1;
      wait_busy_low();
      chk(f_sampling, 1'b1);
      // The bench is the host on this link, so it keeps the quiet zone
      tick(1);
      f_read(16'hBEEF);
      repeat (sad_pkg::QUIET_PRE_CYC) @(posedge clk_i);
      f_trig <= 1'b0;
      tick(1);
      chk(link_f.busy, 1'b1);
      chk(f_sampling, 1'b0);
      repeat (4) @(posedge clk_i);
      f_trig <= 1'b1;
      @(posedge clk_i);
      f_trig <= 1'b0;
      for (int n = 0; n < 4 && f_irst !== 1'b1; n++)
         tick(1);
      chk(f_irst, 1'b1);
      tick(1);
      chk(link_f.busy, 1'b0);
      chk(f_sampling, 1'b1);
      repeat (sad_pkg::QUIET_POST_CYC) @(posedge clk_i);
      f_trig <= 1'b1;
      f_read(16'h0000);
      $display("test trigger abort done");
   endtask : s_abort

   task automatic s_select;
      repeat (sad_pkg::QUIET_PRE_CYC) @(posedge clk_i);
      f_trig <= 1'b0;
      @(posedge clk_i);
      f_sel <= 1'b1;
      @(posedge clk_i);
      f_sel <= 1'b0;
      for (int n = 0; n < 4 && f_irst !== 1'b1; n++)
         tick(1);
      chk(f_irst, 1'b1);
      tick(1);
      chk(link_f.busy, 1'b0);
      @(posedge clk_i);
      f_sel  <= 1'b1;
      f_trig <= 1'b1;
      @(posedge clk_i);
      f_trig <= 1'b0;
      tick(2);
      chk(link_f.busy, 1'b0);
      @(posedge clk_i);
      f_trig <= 1'b1;
      f_sel  <= 1'b0;
      @(posedge clk_i);
      f_trig <= 1'b0;
      @(posedge clk_i);
      f_sel <= 1'b1;
      repeat (4) @(posedge clk_i);
      f_trig <= 1'b1;
      wait_busy_low();
      chk(f_sampling, 1'b0);
      @(posedge clk_i);
      f_sel <= 1'b0;
      tick(2);
      chk(f_sampling, 1'b1);
      $display("test select abort done");
   endtask : s_select

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run

   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      s_trim_and_codes();
      s_fifo();
      s_abort();
      s_select();
      complete_run();
   end

   // About 800 cycles are expected; the margin covers the stall waits
   initial
   begin
      #(20000 * 4);
      n_mismatch++;
      complete_run();
   end

endmodule : tb_sar_adc_parallel_readout
